// ### hw/dbg_acq.sv
// Debug port acquisition window, pin pair selection and link clock crossing
// Functional notes
// - Acquisition window of 8 us opens after reset; later attempts are ignored.
// - Eight link clock pulses inside the short window extend it to 400 us total.
// - Link uses two pins, GPIO pair or USB pair: clock plus bidirectional data.
// - Debug function enabled on at most one pin pair at any time.
// - While USB pair is the link, the GPIO clock pin is withheld from GPIO use.
// - Trace output switches on automatically when the debug link becomes active.
// - Debug and flash programming share the same two-wire link.
`timescale 1ns/1ps
module dbg_acq
  import dbg_acq_pkg::*;
#(
  parameter int unsigned SHORT_CYC = WINDOW_SHORT_CYC,
  parameter int unsigned LONG_CYC  = WINDOW_LONG_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic debug_link_clock_gpio,
  input  wire logic debug_link_clock_usb,
  input  wire logic key_ok_gpio,
  input  wire logic key_ok_usb,
  input  wire logic link_data_out,
  input  wire logic link_data_oe,
  input  wire logic gpio_data_in,
  input  wire logic usb_data_in,
  output logic      link_data_in,
  output logic      gpio_data_out,
  output logic      gpio_data_oe,
  output logic      usb_data_out,
  output logic      usb_data_oe,
  output logic      gpio_clock_pin_claimed,
  output logic      debug_active,
  output logic      trace_output_en,
  output logic      window_open,
  output logic      window_extended,
  output dbg_acq_pkg::pair_sel_t active_pair
);
  import dbg_acq_pkg::*;

  // Two clock domains live here: the host-driven link clock, which only
  // counts pulses, and the system clock, which runs the window timer and
  // the pair choice. The only thing crossing from link to system is one
  // sticky level, so a plain two-stage synchroniser is enough for it.
  // Key flags come from decode logic outside and are treated as async.

  // A key counts only when it arrives on exactly one pair; both at once
  // means the host broke the one-pair rule and the attempt is dropped
  function automatic pair_sel_t pick_pair(input logic key_gpio, input logic key_usb);
    pair_sel_t sel;
    sel = PAIR_NONE;
    if (key_gpio && !key_usb) begin
      sel = PAIR_GPIO;
    end else if (key_usb && !key_gpio) begin
      sel = PAIR_USB;
    end
    return sel;
  endfunction

  // Last cycle of a window of the given length; the timer starts at zero
  function automatic logic at_limit(input logic [TIMER_W-1:0] count, input int unsigned limit);
    logic [TIMER_W-1:0] last;
    last = TIMER_W'(limit - 1);
    return count >= last;
  endfunction

  // A pair owns the pins only after a completed acquire
  function automatic logic pair_owns(input acq_state_t state, input pair_sel_t pair, input pair_sel_t which);
    return (state == ST_ACTIVE) && (pair == which);
  endfunction

  // Link clock is the OR of both candidate clock pins; an idle pair is held low
  logic link_clk;
  assign link_clk = debug_link_clock_gpio | debug_link_clock_usb;

  // Link domain: count clock pulses, raise a level once eight are seen
  typedef struct packed {
    logic [EDGE_W-1:0] edges;
    logic              seen8;
  } link_t;
  link_t lnk, next_lnk;

  always_comb begin
    next_lnk = lnk;
    if (lnk.edges != EDGE_W'(EXTEND_EDGES)) begin
      next_lnk.edges = lnk.edges + EDGE_W'(1);
    end
    next_lnk.seen8 = (next_lnk.edges == EDGE_W'(EXTEND_EDGES));
  end

  // Pulses before reset release are lost on purpose: the count must start
  // with the window, not with whatever the probe did while held in reset
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  // System domain state
  typedef struct packed {
    logic [1:0]         sync8;
    logic [1:0]         sync_kg;
    logic [1:0]         sync_ku;
    logic [TIMER_W-1:0] timer;
    acq_state_t         state;
    pair_sel_t          pair;
  } sys_t;
  sys_t st, next_st;

  logic      timer_done;
  pair_sel_t key_pair;

  always_comb begin
    next_st = st;
    timer_done = 1'b0;
    // Two-stage synchronisers; logic reads only the second stage
    next_st.sync8   = {st.sync8[0], lnk.seen8};
    next_st.sync_kg = {st.sync_kg[0], key_ok_gpio};
    next_st.sync_ku = {st.sync_ku[0], key_ok_usb};
    key_pair = pick_pair(st.sync_kg[1], st.sync_ku[1]);
    case (st.state)
      ST_SHORT: begin
        timer_done = at_limit(st.timer, SHORT_CYC);
        next_st.timer = st.timer + TIMER_W'(1);
        // A key beats an extension landing in the same cycle
        if (key_pair != PAIR_NONE) begin
          next_st.state = ST_ACTIVE;
          next_st.pair  = key_pair;
        end else if (st.sync8[1]) begin
          next_st.state = ST_LONG;
        end else if (timer_done) begin
          next_st.state = ST_CLOSED;
        end
      end
      ST_LONG: begin
        // Timer keeps running: 400 us is the total from reset release
        timer_done = at_limit(st.timer, LONG_CYC);
        next_st.timer = st.timer + TIMER_W'(1);
        if (key_pair != PAIR_NONE) begin
          next_st.state = ST_ACTIVE;
          next_st.pair  = key_pair;
        end else if (timer_done) begin
          next_st.state = ST_CLOSED;
        end
      end
      ST_ACTIVE: begin
        next_st.state = ST_ACTIVE;  // Held until the next reset
      end
      ST_CLOSED: begin
        next_st.state = ST_CLOSED;  // Late keys are never honoured
      end
      default: begin
        next_st.state = ST_CLOSED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Window counts as open during reset; timing starts at release
      st <= '{
        sync8:   2'b00,
        sync_kg: 2'b00,
        sync_ku: 2'b00,
        timer:   '0,
        state:   ST_SHORT,
        pair:    PAIR_NONE
      };
    end else begin
      st <= next_st;
    end
  end

  assign window_open     = (st.state == ST_SHORT) || (st.state == ST_LONG);
  assign window_extended = (st.state == ST_LONG);
  assign active_pair     = st.pair;
  assign debug_active    = (st.state == ST_ACTIVE);
  // Trace follows the link with no enable of its own
  assign trace_output_en = debug_active;
  // Board must pull the idle clock pin low, or the OR above sees noise
  assign gpio_clock_pin_claimed = pair_owns(st.state, st.pair, PAIR_USB);

  // Data pin steering: only the chosen pair carries the debug data, for debug and flash alike
  // Both outputs copy the engine; the enables alone decide who drives
  assign gpio_data_out = link_data_out;
  assign usb_data_out  = link_data_out;
  assign gpio_data_oe  = pair_owns(st.state, st.pair, PAIR_GPIO) && link_data_oe;
  assign usb_data_oe   = pair_owns(st.state, st.pair, PAIR_USB) && link_data_oe;

  // Unclaimed pins read as zero so the engine never sees a stray pin
  always_comb begin
    case (st.pair)
      PAIR_USB: begin
        link_data_in = usb_data_in;
      end
      PAIR_GPIO: begin
        link_data_in = gpio_data_in;
      end
      default: begin
        link_data_in = 1'b0;
      end
    endcase
  end
endmodule

// ### include/dbg_acq_pkg.sv
// Constants and types for the debug port acquisition block
package dbg_acq_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned WINDOW_SHORT_NS = 8_000;
  localparam int unsigned WINDOW_LONG_NS  = 400_000;
  // Both window times round down to whole cycles
  localparam int unsigned WINDOW_SHORT_CYC = (WINDOW_SHORT_NS / 50) > 0 ? (WINDOW_SHORT_NS / 50) : 1;
  localparam int unsigned WINDOW_LONG_CYC  = (WINDOW_LONG_NS / 50) > 0 ? (WINDOW_LONG_NS / 50) : 1;
  localparam int unsigned EXTEND_EDGES     = 8;
  localparam int unsigned TIMER_W          = 16;
  localparam int unsigned EDGE_W           = 4;

  typedef enum logic [1:0] {
    PAIR_NONE,
    PAIR_GPIO,
    PAIR_USB
  } pair_sel_t;

  typedef enum logic [2:0] {
    ST_SHORT,
    ST_LONG,
    ST_ACTIVE,
    ST_CLOSED
  } acq_state_t;
endpackage

// ### test/dbg_acq_chk.sv
// Port assertions for the acquisition block
`timescale 1ns/1ps
module dbg_acq_chk
  import dbg_acq_pkg::*;
#(parameter int unsigned SHORT_CYC = 160, LONG_CYC = 400) (
  input wire logic clk, rst_n, key_ok_gpio, key_ok_usb, gpio_data_oe, usb_data_oe, gpio_clock_pin_claimed,
  input wire logic debug_active, trace_output_en, window_open, window_extended,
  input wire dbg_acq_pkg::pair_sel_t active_pair
);
  logic [15:0] cnt;
  int unsigned lim;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign lim = window_extended ? LONG_CYC : SHORT_CYC;
  // Frozen once closed, so the close time stays readable
  always_ff @(posedge clk or negedge rst_n) cnt <= !rst_n ? 16'h0000 : cnt + 16'(window_open);
  property p_trace; trace_output_en == debug_active; endproperty
  a_trace: assert property (p_trace) else $error("trace enable differs");
  property p_one; !(gpio_data_oe && usb_data_oe); endproperty
  a_one: assert property (p_one) else $error("both pairs driven");
  property p_claim; gpio_clock_pin_claimed == (active_pair == PAIR_USB); endproperty
  a_claim: assert property (p_claim) else $error("clock pin claim wrong");
  property p_late; !window_open && !debug_active |=> !debug_active; endproperty
  a_late: assert property (p_late) else $error("late acquire");
  property p_acq; $rose(key_ok_usb) && !key_ok_gpio && window_open |-> ##3 (debug_active || !window_open); endproperty
  a_acq: assert property (p_acq) else $error("key not taken");
  property p_stay; debug_active |=> debug_active && $stable(active_pair); endproperty
  a_stay: assert property (p_stay) else $error("pair changed");
  property p_closed; !window_open |=> !window_open; endproperty
  a_closed: assert property (p_closed) else $error("window reopened");
  property p_time; $fell(window_open) && !debug_active |-> cnt + 1 >= $past(lim) && cnt <= $past(lim) + 2; endproperty
  a_time: assert property (p_time) else $error("window length wrong");
  cover property (debug_active && active_pair == PAIR_USB);
  cover property ($rose(window_extended));
  cover property ($fell(window_open));
endmodule
bind dbg_acq dbg_acq_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk (.*);

// ### test/host_probe.sv
// Host probe model: link clock bursts and pin data
`timescale 1ns/1ps
module host_probe (input wire logic go, usb, hd, input wire logic [3:0] n, output logic ckg = 1'h0, cku = 1'h0, dg, du);
  // Clock idles low between bursts, 15 ns period
  always @(posedge go) repeat (n) begin
    #7.5 {cku, ckg} = {usb, ~usb};
    #7.5 {cku, ckg} = 2'h0;
  end
  // Unused pair shows the inverse level
  assign {du, dg} = usb ? {hd, ~hd} : {~hd, hd};
endmodule

// ### test/tb_top.sv
// Self-checking bench for the acquisition block
`timescale 1ns/1ps
module tb_top;
  import dbg_acq_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, link_data_out = 1'h0, link_data_oe = 1'h0, key_ok_gpio = 1'h0, key_ok_usb = 1'h0;
  logic go = 1'h0, usb = 1'h0, hd = 1'h0, debug_link_clock_gpio, debug_link_clock_usb, dg, du, link_data_in;
  logic gpio_data_out, gpio_data_oe, usb_data_out, usb_data_oe, gpio_clock_pin_claimed, debug_active;
  logic trace_output_en, window_open, window_extended;
  logic [3:0] n = 4'h8;
  pair_sel_t active_pair;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  wire gpio_data_in = gpio_data_oe ? gpio_data_out : dg;
  wire usb_data_in = usb_data_oe ? usb_data_out : du;
  always #25 clk = ~clk;
  host_probe hp (.go(go), .usb(usb), .hd(hd), .n(n), .ckg(debug_link_clock_gpio), .cku(debug_link_clock_usb), .dg(dg), .du(du));
  dbg_acq #(.LONG_CYC(400)) dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .debug_link_clock_gpio  (debug_link_clock_gpio),
    .debug_link_clock_usb   (debug_link_clock_usb),
    .key_ok_gpio            (key_ok_gpio),
    .key_ok_usb             (key_ok_usb),
    .link_data_out          (link_data_out),
    .link_data_oe           (link_data_oe),
    .gpio_data_in           (gpio_data_in),
    .usb_data_in            (usb_data_in),
    .link_data_in           (link_data_in),
    .gpio_data_out          (gpio_data_out),
    .gpio_data_oe           (gpio_data_oe),
    .usb_data_out           (usb_data_out),
    .usb_data_oe            (usb_data_oe),
    .gpio_clock_pin_claimed (gpio_clock_pin_claimed),
    .debug_active           (debug_active),
    .trace_output_en        (trace_output_en),
    .window_open            (window_open),
    .window_extended        (window_extended),
    .active_pair            (active_pair)
  );
  task chk(input string s, input logic [1:0] v, e);
    samples_checked++;
    if (v !== e) begin num_errors++; $display("ERROR %s expected %h seen %h", s, e, v); end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 2000) begin num_errors++; print_verdict; end
  task rst(input logic [3:0] p, input logic u);
    @(posedge clk);
    {key_ok_usb, key_ok_gpio, link_data_oe, go, rst_n} <= 5'h00;
    {n, usb} <= {p, u};
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    go <= 1'h1;
  endtask
  task t_seven;
    rst(4'h7, 1'h0);
    repeat (150) @(posedge clk);
    chk("open", window_open, 1);
    repeat (20) @(posedge clk);
    chk("open", window_open, 0);
    key_ok_usb <= 1'h1;
    repeat (6) @(posedge clk);
    chk("ext", window_extended, 0);
    chk("act", debug_active, 0);
  endtask
  task t_usb;
    rst(4'h8, 1'h1);
    repeat (200) @(posedge clk);
    chk("ext", window_extended, 1);
    key_ok_usb <= 1'h1;
    repeat (5) @(posedge clk);
    chk("pair", active_pair, PAIR_USB);
    chk("trace", trace_output_en, 1);
    chk("claim", gpio_clock_pin_claimed, 1);
    {link_data_oe, link_data_out} <= 2'h3;
    @(negedge clk) chk("oe", {gpio_data_oe, usb_data_oe}, 1);
    chk("dout", {gpio_data_out, usb_data_out}, 3);
    @(posedge clk) {link_data_oe, hd} <= 2'h1;
    @(negedge clk) chk("din", link_data_in, 1);
  endtask
  task t_both;
    rst(4'h0, 1'h0);
    {key_ok_usb, key_ok_gpio} <= 2'h3;
    repeat (6) @(posedge clk);
    chk("both", debug_active, 0);
    key_ok_usb <= 1'h0;
    repeat (5) @(posedge clk);
    chk("pair", active_pair, PAIR_GPIO);
    chk("claim", gpio_clock_pin_claimed, 0);
  endtask
  task t_long;
    rst(4'h8, 1'h0);
    repeat (200) @(posedge clk);
    chk("ext", window_extended, 1);
    chk("open", window_open, 1);
    repeat (210) @(posedge clk);
    chk("open", window_open, 0);
    key_ok_gpio <= 1'h1;
    repeat (6) @(posedge clk);
    chk("act", debug_active, 0);
    chk("oe", {gpio_data_oe, usb_data_oe}, 0);
  endtask
  initial begin t_seven; t_usb; t_both; t_long; print_verdict; end
endmodule
